//--- fwd_policy_pkg.sv
// constants, offsets and types for the switch forwarding policy block
package fwd_policy_pkg;
   localparam int NUM_PORTS = 26;
   localparam int PORT_W = 5;
   localparam int LOW_PORTS = 16;
   localparam int HIGH_PORTS = 10;
   // printed offsets are indexes; byte address is four times the index
   localparam logic [7:0] IDX_PORT_DISABLE_LOW = 8'h9e;
   localparam logic [7:0] IDX_PORT_DISABLE_HIGH = 8'h9f;
   localparam logic [7:0] IDX_IGMP_SNOOP_ENABLE_LOW = 8'ha0;
   localparam logic [7:0] IDX_IGMP_SNOOP_AND_MCAST_CTRL = 8'ha1;
   localparam logic [7:0] IDX_CPU_PORT_CONTROL = 8'ha2;
   localparam logic [7:0] IDX_RESERVED_DA_FORWARD_CTRL = 8'ha3;
   localparam int ADDR_W = 12;
   // field positions
   localparam int MCAST_CTRL_LSB = 10;
   localparam int CPU_PORT_LSB = 0;
   localparam int RX_TAG_EN_BIT = 5;
   localparam int TX_TAG_EN_BIT = 6;
   localparam int PAUSE_TAG_BIT = 7;
   localparam int LEARN_GROUP_LSB = 11;
   localparam int CPU_LEARN_DIS_BIT = 13;
   // reset values
   localparam logic [15:0] RST_PORT_DISABLE = 16'h0000;
   localparam logic [15:0] RST_IGMP = 16'h0000;
   localparam logic [15:0] RST_CPU_CTRL = 16'h001f;
   localparam logic [15:0] RST_RSV_FWD = 16'h0004;
   // writable masks
   localparam logic [15:0] MASK_HIGH_PORTS = 16'h03ff;
   localparam logic [15:0] MASK_IGMP_HIGH = 16'h0fff;
   localparam logic [15:0] MASK_CPU_CTRL = 16'h38ff;
   // frame constants
   localparam logic [23:0] IGMP_DA_PREFIX = 24'h0100_5e;
   localparam logic [15:0] TYPE_IPV4 = 16'h0800;
   localparam logic [3:0] IP_VERSION_4 = 4'h4;
   localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
   localparam logic [39:0] RSV_DA_PREFIX = 40'h0180_c200_00;
   localparam logic [15:0] TYPE_MAC_CTRL = 16'h8808;
   localparam logic [15:0] OPCODE_PAUSE = 16'h0001;
   localparam logic [4:0] NO_CPU_PORT = 5'h1f;
   localparam int RX_TAG_BYTES = 8;
   localparam int TX_TAG_BYTES = 4;
   typedef enum logic [1:0] {
      MC_FLOOD = 2'b00, MC_TO_CPU = 2'b01, MC_DISCARD = 2'b10,
      MC_RESERVED = 2'b11
   } mcast_action_t;
   typedef enum logic [1:0] {
      RF_NORMAL = 2'b00, RF_DISCARD = 2'b01, RF_CPU_ELSE_NORMAL = 2'b10,
      RF_CPU_ELSE_DROP = 2'b11
   } rsv_option_t;
   typedef enum logic [1:0] {
      LG_SA_ONLY0 = 2'b00, LG_SA_ONLY1 = 2'b01, LG_SA_VID0 = 2'b10,
      LG_SA_VID5 = 2'b11
   } learn_mode_t;
endpackage : fwd_policy_pkg

//--- frame_classifier.sv
// header classifier: igmp and reserved destination range decode
`timescale 1ns/1ps
module frame_classifier
   import fwd_policy_pkg::*;
(
   input wire logic [47:0] da,
   input wire logic [15:0] len_type,
   input wire logic [3:0] ip_version,
   input wire logic [7:0] ip_protocol,
   input wire logic [15:0] mac_ctrl_opcode,
   output logic is_igmp,
   output logic is_reserved,
   output logic [2:0] rsv_range,
   output logic is_broadcast,
   output logic is_multicast
);
   logic [7:0] low;
   assign low = da[7:0];
   assign is_broadcast = &da;
   // group bit of the first octet
   assign is_multicast = da[40];
   assign is_igmp = (da[47:24] == IGMP_DA_PREFIX) &&
      (len_type == TYPE_IPV4) && (ip_version == IP_VERSION_4) &&
      (ip_protocol == IP_PROTO_IGMP);
   // reserved range select; pause DA only for non-pause opcodes
   always_comb begin
      is_reserved = (da[47:8] == RSV_DA_PREFIX);
      rsv_range = 3'd0;
      if (low == 8'h00) begin
         rsv_range = 3'd0;
      end else if (low == 8'h01) begin
         rsv_range = 3'd1;
         if (len_type != TYPE_MAC_CTRL || mac_ctrl_opcode == OPCODE_PAUSE)
         begin
            is_reserved = 1'b0;
         end
      end else if (low == 8'h02) begin
         rsv_range = 3'd2;
      end else if (low == 8'h03) begin
         rsv_range = 3'd3;
      end else if (low <= 8'h0f) begin
         rsv_range = 3'd4;
      end else if (low <= 8'h1f) begin
         rsv_range = 3'd5;
      end else if (low <= 8'h22) begin
         rsv_range = 3'd6;
      end else begin
         rsv_range = 3'd7;
      end
   end
endmodule : frame_classifier

//--- apb_regs.sv
// apb slave holding the six policy registers
`timescale 1ns/1ps
module apb_regs
   import fwd_policy_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] port_disable_low,
   output logic [15:0] port_disable_high,
   output logic [15:0] igmp_snoop_enable_low,
   output logic [15:0] igmp_snoop_and_mcast_ctrl,
   output logic [15:0] cpu_port_control,
   output logic [15:0] reserved_da_forward_ctrl
);
   logic [7:0] idx;
   logic hit;
   logic wr;
   logic [15:0] rd;
   assign idx = paddr[9:2];
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite && hit;
   always_comb begin
      hit = 1'b1;
      rd = 16'h0000;
      unique case (idx)
         IDX_PORT_DISABLE_LOW: rd = port_disable_low;
         IDX_PORT_DISABLE_HIGH: rd = port_disable_high;
         IDX_IGMP_SNOOP_ENABLE_LOW: rd = igmp_snoop_enable_low;
         IDX_IGMP_SNOOP_AND_MCAST_CTRL: rd = igmp_snoop_and_mcast_ctrl;
         IDX_CPU_PORT_CONTROL: rd = cpu_port_control;
         IDX_RESERVED_DA_FORWARD_CTRL: rd = reserved_da_forward_ctrl;
         default: hit = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:10] != '0) begin
         hit = 1'b0;
      end
   end
   // unmapped address: error answer; reads zero unless paddr[9:2] still matches a register, which then reads back
   assign pslverr = psel && penable && !hit;
   assign prdata = {16'h0000, rd};
   // all disable bits reset to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_disable_low <= RST_PORT_DISABLE;
         port_disable_high <= RST_PORT_DISABLE;
         igmp_snoop_enable_low <= RST_IGMP;
         igmp_snoop_and_mcast_ctrl <= RST_IGMP;
         cpu_port_control <= RST_CPU_CTRL;
         reserved_da_forward_ctrl <= RST_RSV_FWD;
      end else if (wr) begin
         unique case (idx)
            IDX_PORT_DISABLE_LOW: port_disable_low <= pwdata[15:0];
            IDX_PORT_DISABLE_HIGH:
               port_disable_high <= pwdata[15:0] & MASK_HIGH_PORTS;
            IDX_IGMP_SNOOP_ENABLE_LOW: igmp_snoop_enable_low <= pwdata[15:0];
            IDX_IGMP_SNOOP_AND_MCAST_CTRL:
               igmp_snoop_and_mcast_ctrl <= pwdata[15:0] & MASK_IGMP_HIGH;
            IDX_CPU_PORT_CONTROL:
               cpu_port_control <= pwdata[15:0] & MASK_CPU_CTRL;
            default: reserved_da_forward_ctrl <= pwdata[15:0];
         endcase
      end
   end
endmodule : apb_regs

//--- switch_forward_policy_ctrl.sv
// forwarding policy decision for one received frame header per request
`timescale 1ns/1ps
// How it works
// - disabled port neither receives nor transmits
// - no learning on disabled port; reset zero
// - igmp frames go to cpu when snooping
// - one snooping bit per port, reset zero
// - igmp on non-snooping port uses multicast control
// - unknown non-reserved multicast uses multicast control
// - multicast control: flood, cpu, discard, reserved
// - five-bit cpu port, reset means none
// - cpu prefixes 8-byte tag; device strips it
// - transmit tag enable adds 4-byte cpu tag
// - pause tag bit adds tag on pause when transmit tag enable is set
// - learning group modes sa or sa+vid0
// - mode 11 learns with sa+vid[4:0]
// - cpu port learning can be disabled
// - 2-bit option per reserved range
// - pause DA non-pause opcodes, reset 01
// - reserved option encoding with cpu exceptions
// - tagged cpu frames with vector bypass options
module switch_forward_policy_ctrl
   import fwd_policy_pkg::*;
#(
   parameter int PORTS = NUM_PORTS
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fwd_policy_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic [4:0] rx_port,
   input wire logic [47:0] da,
   input wire logic [15:0] len_type,
   input wire logic [3:0] ip_version,
   input wire logic [7:0] ip_protocol,
   input wire logic [15:0] mac_ctrl_opcode,
   input wire logic da_in_table,
   input wire logic [PORTS-1:0] table_vector,
   input wire logic [PORTS-1:0] group_members,
   input wire logic [11:0] vid,
   input wire logic rx_tag_present,
   input wire logic rx_tag_vector_valid,
   input wire logic [PORTS-1:0] rx_tag_vector,
   input wire logic pause_event,
   output logic dec_valid,
   output logic [PORTS-1:0] dest_vector,
   output logic drop,
   output logic learn_enable,
   output logic [4:0] learning_group_index,
   output logic strip_rx_tag,
   output logic [PORTS-1:0] port_rx_enable,
   output logic [PORTS-1:0] port_tx_enable,
   output logic [PORTS-1:0] insert_tx_tag,
   output logic pause_tag_insert
);
   // register bit mapping is fixed to the documented port count
   if (PORTS != NUM_PORTS) begin : g_bad_ports
      $error("port count must be 26");
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] port_disable_low;
   logic [15:0] port_disable_high;
   logic [15:0] igmp_snoop_enable_low;
   logic [15:0] igmp_snoop_and_mcast_ctrl;
   logic [15:0] cpu_port_control;
   logic [15:0] reserved_da_forward_ctrl;

   apb_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .port_disable_low(port_disable_low),
      .port_disable_high(port_disable_high),
      .igmp_snoop_enable_low(igmp_snoop_enable_low),
      .igmp_snoop_and_mcast_ctrl(igmp_snoop_and_mcast_ctrl),
      .cpu_port_control(cpu_port_control),
      .reserved_da_forward_ctrl(reserved_da_forward_ctrl)
   );

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   logic [PORTS-1:0] port_disabled;
   logic [PORTS-1:0] snoop_en;
   logic [PORTS-1:0] cpu_mask;
   mcast_action_t mcast_action;
   learn_mode_t learn_mode;
   logic [4:0] cpu_port;
   logic cpu_present;
   logic rx_tag_en;
   logic tx_tag_en;
   logic pause_tag_en;
   logic cpu_learn_dis;

   assign port_disabled = {port_disable_high[HIGH_PORTS-1:0],
      port_disable_low};
   assign snoop_en = {igmp_snoop_and_mcast_ctrl[HIGH_PORTS-1:0],
      igmp_snoop_enable_low};
   assign mcast_action = mcast_action_t'(
      igmp_snoop_and_mcast_ctrl[MCAST_CTRL_LSB +: 2]);
   assign cpu_port = cpu_port_control[CPU_PORT_LSB +: PORT_W];
   assign rx_tag_en = cpu_port_control[RX_TAG_EN_BIT];
   assign tx_tag_en = cpu_port_control[TX_TAG_EN_BIT];
   assign pause_tag_en = cpu_port_control[PAUSE_TAG_BIT];
   assign learn_mode = learn_mode_t'(
      cpu_port_control[LEARN_GROUP_LSB +: 2]);
   assign cpu_learn_dis = cpu_port_control[CPU_LEARN_DIS_BIT];

   // numbers past the last port mean no cpu port
   assign cpu_present = (cpu_port < 5'(PORTS)) && (cpu_port != NO_CPU_PORT);

   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_port
         assign cpu_mask[g] = cpu_present && (cpu_port == 5'(g));
         // disabled ports neither receive nor transmit
         assign port_rx_enable[g] = !port_disabled[g];
         assign port_tx_enable[g] = !port_disabled[g];
         // tag on every frame sent to the cpu port while transmit tag enable is set
         assign insert_tx_tag[g] = tx_tag_en && cpu_mask[g];
      end
   endgenerate

   assign pause_tag_insert = pause_event && tx_tag_en && pause_tag_en &&
      cpu_present;

   // ------------------------------------------------------------
   // classification
   // ------------------------------------------------------------
   logic is_igmp;
   logic is_reserved;
   logic [2:0] rsv_range;
   logic is_broadcast;
   logic is_multicast;

   frame_classifier u_class (
      .da(da),
      .len_type(len_type),
      .ip_version(ip_version),
      .ip_protocol(ip_protocol),
      .mac_ctrl_opcode(mac_ctrl_opcode),
      .is_igmp(is_igmp),
      .is_reserved(is_reserved),
      .rsv_range(rsv_range),
      .is_broadcast(is_broadcast),
      .is_multicast(is_multicast)
   );

   // ------------------------------------------------------------
   // decision
   // ------------------------------------------------------------
   logic from_cpu;
   logic rx_ok;
   logic port_ok;
   logic [PORTS-1:0] flood_vec;
   logic [PORTS-1:0] normal_vec;
   logic [PORTS-1:0] next_vector;
   logic next_drop;
   logic next_learn;
   logic [4:0] next_lg;
   rsv_option_t rsv_opt;

   assign port_ok = rx_port < 5'(PORTS);
   assign from_cpu = cpu_present && (rx_port == cpu_port);
   assign rx_ok = port_ok && !port_disabled[rx_port];
   assign rsv_opt = rsv_option_t'(reserved_da_forward_ctrl[rsv_range*2 +: 2]);
   assign flood_vec = group_members & ~(PORTS'(1) << rx_port);
   assign normal_vec = da_in_table ? table_vector : flood_vec;

   always_comb begin
      next_vector = normal_vec;
      next_drop = 1'b0;
      // tag vector from the cpu decides forwarding
      if (from_cpu && rx_tag_en && rx_tag_present && rx_tag_vector_valid)
      begin
         next_vector = rx_tag_vector;
      end else if (is_reserved) begin
         unique case (rsv_opt)
            RF_NORMAL: next_vector = normal_vec;
            RF_DISCARD: next_drop = 1'b1;
            RF_CPU_ELSE_NORMAL: begin
               if (!from_cpu) begin
                  next_vector = cpu_mask;
               end
            end
            RF_CPU_ELSE_DROP: begin
               if (from_cpu) begin
                  next_drop = 1'b1;
               end else begin
                  next_vector = cpu_mask;
               end
            end
         endcase
      end else if (is_igmp && snoop_en[rx_port]) begin
         next_vector = cpu_mask;
      end else if ((is_igmp || (!da_in_table && is_multicast &&
            !is_broadcast)) && !is_reserved) begin
         unique case (mcast_action)
            MC_FLOOD: next_vector = flood_vec;
            MC_TO_CPU: next_vector = cpu_mask;
            MC_DISCARD: next_drop = 1'b1;
            MC_RESERVED: next_vector = flood_vec;
         endcase
      end
      // never send out of a disabled port
      next_vector = next_vector & ~port_disabled;
      if (!rx_ok) begin
         next_drop = 1'b1;
      end
      // cpu-bound with no cpu delivers nothing
      if (next_vector == '0) begin
         next_drop = 1'b1;
      end
      if (next_drop) begin
         next_vector = '0;
      end
   end

   assign next_learn = rx_ok && !(from_cpu && cpu_learn_dis);

   always_comb begin
      unique case (learn_mode)
         LG_SA_VID0: next_lg = {4'h0, vid[0]};
         LG_SA_VID5: next_lg = vid[4:0];
         default: next_lg = 5'h00;
      endcase
   end

   // ------------------------------------------------------------
   // registered answer, one cycle after the request
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid <= 1'b0;
      end else begin
         dec_valid <= req_valid;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_vector <= '0;
         drop <= 1'b0;
         learn_enable <= 1'b0;
         learning_group_index <= 5'h00;
         strip_rx_tag <= 1'b0;
      end else if (req_valid) begin
         dest_vector <= next_vector;
         drop <= next_drop;
         learn_enable <= next_learn;
         learning_group_index <= next_lg;
         strip_rx_tag <= from_cpu && rx_tag_en;
      end
   end
endmodule : switch_forward_policy_ctrl

//--- fwd_policy_sva.sv
// port assertions for the forwarding policy block
`timescale 1ns/1ps
module fwd_policy_sva #(
   parameter int PORTS = 26
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic req_valid,
   input wire logic [4:0] rx_port,
   input wire logic dec_valid,
   input wire logic [PORTS-1:0] dest_vector,
   input wire logic drop,
   input wire logic learn_enable,
   input wire logic [PORTS-1:0] port_rx_enable,
   input wire logic [PORTS-1:0] port_tx_enable,
   input wire logic [PORTS-1:0] insert_tx_tag,
   input wire logic pause_tag_insert,
   input wire logic pause_event
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   dec_latency_a: assert property (req_valid |=> dec_valid)
      else $error("decision not one cycle after request");
   dec_spurious_a: assert property (!req_valid |=> !dec_valid)
      else $error("decision without request");
   dis_drop_a: assert property (
      req_valid && rx_port < PORTS && !port_rx_enable[rx_port]
      |=> drop && dest_vector == '0)
      else $error("disabled port frame not dropped");
   dis_learn_a: assert property (
      req_valid && rx_port < PORTS && !port_rx_enable[rx_port]
      |=> !learn_enable)
      else $error("disabled port frame learned");
   tx_mask_a: assert property (
      dec_valid |-> (dest_vector & ~port_tx_enable) == '0)
      else $error("frame sent to disabled port");
   enable_pair_a: assert property (
      port_rx_enable == port_tx_enable)
      else $error("receive and transmit enables differ");
   drop_empty_a: assert property (dec_valid && drop |-> dest_vector == '0)
      else $error("dropped frame has destinations");
   tag_onehot_a: assert property ($onehot0(insert_tx_tag))
      else $error("tag inserted on more than one port");
   pause_cause_a: assert property (
      pause_tag_insert |-> pause_event && insert_tx_tag != '0)
      else $error("pause tag without cause");
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
endmodule : fwd_policy_sva

//--- mgmt_cpu_model.sv
// behavioural management cpu: receive tag prefix and pause source
`timescale 1ns/1ps
module mgmt_cpu_model (
   input wire logic pclk,
   input wire logic tag_en,
   input wire logic send,
   input wire logic vec_ok,
   input wire logic [25:0] vec,
   input wire logic pause_req,
   output logic rx_tag_present,
   output logic rx_tag_vector_valid,
   output logic [25:0] rx_tag_vector,
   output logic pause_event
);
   // toggling filler so a stale vector never looks valid
   logic [25:0] junk = 26'h155_5555;
   always @(posedge pclk) junk <= ~junk;
   assign rx_tag_present = send && tag_en;
   assign rx_tag_vector_valid = rx_tag_present && vec_ok;
   assign rx_tag_vector = rx_tag_present ? vec : junk;
   assign pause_event = pause_req;
endmodule : mgmt_cpu_model

//--- switch_forward_policy_ctrl_bench.sv
// self-checking bench for the forwarding policy block
`timescale 1ns/1ps
module switch_forward_policy_ctrl_bench;
   import fwd_policy_pkg::*;
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin errors++; \
$display("MISMATCH %s exp %h got %h", n, e, s); end end
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0, vid = '0;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic pready, pslverr, rerr, req_valid = 0, da_in_table = 0;
   logic [4:0] rx_port = '0, cpu = 5'h1f, learning_group_index;
   logic [47:0] da = '0;
   logic [15:0] len_type = '0, mac_ctrl_opcode = 16'h0002, d;
   logic [25:0] table_vector = '0, group_members = '0, tvec = '0, dis = '0;
   logic [25:0] dest_vector, port_rx_enable, port_tx_enable, insert_tx_tag;
   logic [25:0] rx_tag_vector;
   logic snd = 0, vok = 0, pause_req = 0, tg = 0, rxt = 0, cld = 0;
   logic rx_tag_present, rx_tag_vector_valid, pause_event, dec_valid, drop;
   logic learn_enable, strip_rx_tag, pause_tag_insert;
   logic [1:0] lmode = '0;
   logic [3:0] ipv = 4'h4;
   logic [7:0] ipp = 8'h02;
   logic [33:0] exq[$];
   logic [33:0] got, want;
   logic [7:0] ri[6] = '{8'h9e, 8'h9f, 8'ha0, 8'ha1, 8'ha2, 8'ha3};
   logic [15:0] rv[6] = '{0, 0, 0, 0, 16'h001f, 16'h0004};
   logic [15:0] rm[6] = '{16'hffff, 16'h03ff, 16'hffff, 16'h0fff,
      16'h38ff, 16'hffff};
   logic [7:0] rlo[8] = '{0, 1, 2, 3, 8'h0f, 8'h1a, 8'h22, 8'hff};
   int mk[4] = '{1, 2, 3, 1};
   int rk[4] = '{1, 3, 2, 2};
   int rc[4] = '{1, 3, 1, 3};
   int errors = 0, checks = 0;
   initial forever #20 pclk = ~pclk;
   switch_forward_policy_ctrl #(.PORTS(26)) i_dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .req_valid, .rx_port, .da, .len_type, .ip_version(ipv),
      .ip_protocol(ipp), .mac_ctrl_opcode, .da_in_table, .table_vector,
      .group_members, .vid, .rx_tag_present, .rx_tag_vector_valid,
      .rx_tag_vector, .pause_event, .dec_valid, .dest_vector, .drop,
      .learn_enable, .learning_group_index, .strip_rx_tag, .port_rx_enable,
      .port_tx_enable, .insert_tx_tag, .pause_tag_insert);
   mgmt_cpu_model i_cpu (.pclk, .tag_en(rxt), .send(snd), .vec_ok(vok),
      .vec(tvec), .pause_req, .rx_tag_present, .rx_tag_vector_valid,
      .rx_tag_vector, .pause_event);
   task automatic end_sim;
      if (errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [7:0] i,
         input logic [15:0] wd);
      int n;
      req_valid <= 0;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge pclk) penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         end_sim;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] i, input logic [15:0] wd);
      apb(1, i, wd);
      case (i)
         8'h9e: dis[15:0] = wd;
         8'h9f: dis[25:16] = wd[9:0];
         8'ha2: {cld, lmode, rxt, cpu} = {wd[13:11], wd[5], wd[4:0]};
         default: ;
      endcase
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [15:0] e,
         input logic er);
      apb(0, i, 16'h0000);
      `CHK("prdata", {16'h0000, e}, rdat)
      `CHK("pslverr", er, rerr)
   endtask : rd
   // k picks the raw route: table, flood, cpu, none, tag vector
   task automatic send(input logic [4:0] r, input logic [47:0] a,
         input logic [15:0] lt, input int k);
      logic [25:0] gm, tv, raw, v;
      logic [11:0] vg;
      gm = 26'($urandom);
      tv = 26'($urandom) & ~(26'd1 << r);
      vg = 12'($urandom);
      case (k)
         0: raw = tv;
         1: raw = gm & ~(26'd1 << r);
         2: raw = cpu < 26 ? 26'd1 << cpu : '0;
         3: raw = '0;
         default: raw = tvec;
      endcase
      v = dis[r] ? '0 : raw & ~dis;
      exq.push_back({v, v == '0, !dis[r] && !(cld && r == cpu),
         lmode == 3 ? vg[4:0] : lmode == 2 ? {4'd0, vg[0]} : 5'd0,
         rxt && tg && r == cpu});
      req_valid <= 1;
      rx_port <= r;
      da <= a;
      len_type <= lt;
      table_vector <= tv;
      group_members <= gm;
      vid <= vg;
      snd <= tg;
      da_in_table <= k == 0;
      @(posedge pclk);
   endtask : send
   always @(posedge pclk) begin
      if (dec_valid === 1'b1) begin
         got = {dest_vector, drop, learn_enable, learning_group_index,
            strip_rx_tag};
         want = exq.size() ? exq.pop_front() : ~got;
         `CHK("decision", want, got)
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      end_sim;
   end
   initial begin
      void'($urandom(75310));
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      foreach (ri[j]) rd(ri[j], rv[j], 0);
      foreach (ri[j]) begin
         d = 16'($urandom);
         apb(1, ri[j], d);
         rd(ri[j], d & rm[j], 0);
      end
      wr(8'hc0, 16'hffff);
      rd(8'hc0, 16'h0000, 1);
      wr(8'h9e, 16'h0008);
      wr(8'h9f, 16'h0010);
      wr(8'ha0, 16'h0004);
      wr(8'ha1, 16'h0800);
      wr(8'ha2, 16'h0047);
      wr(8'ha3, 16'h0000);
      `CHK("rx_en", ~dis, port_rx_enable)
      `CHK("tx_en", ~dis, port_tx_enable)
      `CHK("tx_tag", 26'd1 << 7, insert_tx_tag)
      send(5'd5, 48'h0011_2233_4455, 16'h0800, 0);
      send(5'd3, 48'h0011_2233_4455, 16'h0800, 0);
      send(5'd20, 48'h0011_2233_4455, 16'h0800, 0);
      send(5'd2, 48'h0100_5e00_0001, 16'h0800, 2);
      // wrong protocol or version: plain unknown multicast, discarded
      ipp <= 8'h11;
      send(5'd2, 48'h0100_5e00_0001, 16'h0800, 3);
      ipp <= 8'h02;
      ipv <= 4'h6;
      send(5'd2, 48'h0100_5e00_0001, 16'h0800, 3);
      ipv <= 4'h4;
      send(5'd9, 48'hffff_ffff_ffff, 16'h0806, 1);
      send(5'd9, 48'h0022_0000_0001, 16'h0806, 1);
      for (int m = 0; m < 4; m++) begin
         wr(8'ha1, 16'(m) << 10);
         send(5'd4, 48'h0100_5e00_0001, 16'h0800, mk[m]);
         send(5'd9, 48'h0100_5e12_3456, 16'h0806, mk[m]);
      end
      wr(8'ha1, 16'h0800);
      mac_ctrl_opcode <= 16'h0001;
      send(5'd9, 48'h0180_c200_0001, 16'h8808, 3);
      mac_ctrl_opcode <= 16'h0002;
      for (int o = 0; o < 4; o++) begin
         wr(8'ha3, 16'(o) * 16'h5555);
         foreach (rlo[i]) begin
            d = i == 1 ? 16'h8808 : 16'h0806;
            send(5'd9, {40'h0180_c200_00, rlo[i]}, d, rk[o]);
            send(5'd7, {40'h0180_c200_00, rlo[i]}, d, rc[o]);
         end
      end
      wr(8'ha2, 16'h0067);
      tg <= 1;
      vok <= 1;
      tvec <= 26'($urandom) & ~26'h000_0080;
      @(posedge pclk);
      send(5'd7, 48'h0180_c200_0000, 16'h0806, 4);
      vok <= 0;
      send(5'd7, 48'h0180_c200_0000, 16'h0806, 3);
      tg <= 0;
      for (int l = 0; l < 8; l++) begin
         wr(8'ha2, {2'b00, 3'(l), 11'h007});
         send(5'd7, 48'h0011_2233_4455, 16'h0800, 0);
         send(5'd6, 48'h0011_2233_4455, 16'h0800, 0);
      end
      wr(8'ha2, 16'h005c);
      `CHK("tx_tag", 26'h000_0000, insert_tx_tag)
      send(5'd2, 48'h0100_5e00_0001, 16'h0800, 2);
      wr(8'ha2, 16'h00c7);
      pause_req <= 1;
      @(posedge pclk);
      `CHK("pause_tag", 1'b1, pause_tag_insert)
      wr(8'ha2, 16'h0087);
      `CHK("pause_tag", 1'b0, pause_tag_insert)
      wr(8'ha2, 16'h0047);
      `CHK("pause_tag", 1'b0, pause_tag_insert)
      repeat (3) @(posedge pclk);
      `CHK("pending", 0, exq.size())
      end_sim;
   end
endmodule : switch_forward_policy_ctrl_bench
bind switch_forward_policy_ctrl fwd_policy_sva #(.PORTS(PORTS)) i_sva (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .req_valid,
   .rx_port, .dec_valid, .dest_vector, .drop, .learn_enable,
   .port_rx_enable, .port_tx_enable, .insert_tx_tag, .pause_tag_insert,
   .pause_event);
